//--- rtl/psw_pkg.sv
// Package: constants for the processor supervisor watchdog reset block
package psw_pkg;

    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;

    // Time base tick: 1 us
    localparam int TICK_US = 1;
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;

    // Reset hold, least time, in ms
    localparam int HOLD_MS = 250;
    localparam int HOLD_TICKS = HOLD_MS * 1000 / TICK_US;

    // Manual reset debounce; must settle inside the 20 ms limit
    localparam int PDLY_MAX_MS = 20;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;

    // Power fail detect to reset, longest time, in us
    localparam int PFAIL_MAX_US = 175;
    localparam int PFAIL_MAX_CYC = PFAIL_MAX_US * CLK_HZ / 1_000_000;

    // Watchdog typical timeouts, in ms
    localparam int WD_GND_MS = 150;
    localparam int WD_FLOAT_MS = 600;
    localparam int WD_VCC_MS = 1200;
    localparam int WD_GND_TICKS = WD_GND_MS * 1000 / TICK_US;
    localparam int WD_FLOAT_TICKS = WD_FLOAT_MS * 1000 / TICK_US;
    localparam int WD_VCC_TICKS = WD_VCC_MS * 1000 / TICK_US;

    // Maximum strobe intervals the processor must keep, in us
    localparam int WD_GND_MIN_US = 62_500;
    localparam int WD_FLOAT_MIN_US = 250_000;
    localparam int WD_VCC_MIN_US = 500_000;

    localparam int TICK_W = 24;

    // -------------------------------------------------------------
    // Delay select encoding
    // -------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PSW_TD_GND = 2'h0,
        PSW_TD_FLOAT = 2'h1,
        PSW_TD_VCC = 2'h2
    } psw_td_t;

    localparam int SYNC_STAGES = 2;

endpackage : psw_pkg

//--- rtl/psw_sync.sv
// Two flip-flop synchroniser for one level input
module psw_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic i_d,
    output logic o_q
);

    logic s1_r;
    logic s1_nxt;
    logic s2_r;
    logic s2_nxt;

    always_comb
    begin
        s1_nxt = i_d;
        s2_nxt = s1_r;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
        end
        else
        begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign o_q = s2_r;

endmodule : psw_sync

//--- rtl/psw_tick.sv
// Divider producing a one-cycle time base enable
module psw_tick
#(
    parameter int DIV = 10
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Enable pulse
    output logic o_tick
);

    initial
    begin
        if (DIV < 1)
            $error("psw_tick: DIV must be at least 1");
        // The divider counter is only 16 bits wide
        if (DIV > 65536)
            $error("psw_tick: DIV exceeds divider counter");
    end

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        if (cnt_r >= 16'(DIV - 1))
        begin
            cnt_nxt = 16'h0;
            tick_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 16'h1;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_r <= 16'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_tick = tick_r;

endmodule : psw_tick

//--- rtl/psw_top.sv
// Top: processor supervisor with power fail, manual reset and watchdog
//
// Contract
// [RULE1] An active power-fail indication forces both reset outputs active.
// [RULE2] After power-up or supply recovery both resets stay active at least 250 ms.
// [RULE3] Reset is asserted no later than 175 us after power fail is seen.
// [RULE4] Two reset outputs carry one state, active high and active low open drain.
// [RULE5] Manual reset is active low, debounced, and asserts reset while held low.
// [RULE6] Release of manual reset starts a hold of at least 250 ms with resets active.
// [RULE7] Reset is asserted within 20 ms of manual reset being stably low.
// [RULE8] Delay select picks 150 ms grounded, 600 ms floating, 1.2 s tied high.
// [RULE9] Watchdog counting starts as soon as both resets go inactive.
// [RULE10] Each strobe falling edge before expiry restarts the watchdog period.
// [RULE11] Watchdog expiry drives both resets active for at least 250 ms.
// [RULE12] The processor strobes within 62.5, 250 or 500 ms for the chosen setting.
// [RULE13] The watchdog cannot be disabled and runs whenever reset is released.
// [RULE14] The processor should derive the strobe from routine bus activity.
// [RULE15] All sources are ORed and any active source restarts the hold period.
// [RULE16] Inputs are synchronised and all delays come from clock counters. The code reads I_TIMEOUT_SELECT live, without a synchroniser.
module psw_top
import psw_pkg::*;
#(
    parameter int HOLD_T = HOLD_TICKS,
    parameter int DEBOUNCE_T = DEBOUNCE_TICKS,
    parameter int WD_GND_T = WD_GND_TICKS,
    parameter int WD_FLOAT_T = WD_FLOAT_TICKS,
    parameter int WD_VCC_T = WD_VCC_TICKS,
    parameter int TICK_DIV = TICK_CYC
)
(
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Supervised sources
    input wire logic I_POWER_FAIL,
    input wire logic I_MANUAL_RESET_N,
    input wire logic I_WATCHDOG_STROBE_N,
    input wire psw_pkg::psw_td_t I_TIMEOUT_SELECT,
    // Reset outputs
    output logic O_RESET,
    output logic O_RESET_N_OUT,
    output logic O_RESET_N_OE,
    // Status
    output logic O_WATCHDOG_EXPIRED
);

    import psw_pkg::*;

    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    // Values the counters cannot hold are refused before any run
    initial
    begin
        if (HOLD_T < 1 || DEBOUNCE_T < 1 || WD_GND_T < 1 || WD_FLOAT_T < 1 || WD_VCC_T < 1)
            $error("psw_top: tick counts must be at least 1");
        if (HOLD_T >= (1 << TICK_W) || WD_VCC_T >= (1 << TICK_W))
            $error("psw_top: tick counts exceed counter width");
        // Unused select code falls back to the longest setting
        if (WD_GND_T > WD_FLOAT_T || WD_FLOAT_T > WD_VCC_T)
            $error("psw_top: timeouts must not fall as the select code rises");
        if (TICK_DIV < 1)
            $error("psw_top: tick divider must be at least 1");
        if (longint'(DEBOUNCE_T) * TICK_US >= longint'(PDLY_MAX_MS) * 1000)
            $error("psw_top: debounce exceeds manual reset response limit");
        if (TICK_DIV > PFAIL_MAX_CYC)
            $error("psw_top: tick divider too slow");
    end

    // ---------------------------------------------------------------
    // Input synchronisers and time base
    // ---------------------------------------------------------------
    logic pfail_s;
    logic mr_n_s;
    logic stb_n_s;
    logic tick;

    // Power fail reads as active until the synchroniser has seen the pin
    psw_sync #(.RESET_VAL(1'b1)) u_sync_pf // see [RULE16]
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d(I_POWER_FAIL),
        .o_q(pfail_s)
    );

    psw_sync #(.RESET_VAL(1'b1)) u_sync_mr // see [RULE16]
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d(I_MANUAL_RESET_N),
        .o_q(mr_n_s)
    );

    psw_sync #(.RESET_VAL(1'b1)) u_sync_st // see [RULE16]
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d(I_WATCHDOG_STROBE_N),
        .o_q(stb_n_s)
    );

    psw_tick #(.DIV(TICK_DIV)) u_tick
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .o_tick(tick)
    );

    // ---------------------------------------------------------------
    // Manual reset debounce
    // ---------------------------------------------------------------
    // Level must stay put for DEBOUNCE_T ticks before it is accepted
    // A bouncing release restarts the count and so stretches the hold
    logic mr_act_r;
    logic mr_act_nxt;
    logic [TICK_W-1:0] db_cnt_r;
    logic [TICK_W-1:0] db_cnt_nxt;

    always_comb
    begin
        mr_act_nxt = mr_act_r;
        db_cnt_nxt = db_cnt_r;
        if ((!mr_n_s) == mr_act_r)
        begin
            db_cnt_nxt = '0;
        end
        else if (tick)
        begin
            if (db_cnt_r >= TICK_W'(DEBOUNCE_T - 1))
            begin
                mr_act_nxt = !mr_n_s; // see [RULE5] [RULE7]
                db_cnt_nxt = '0;
            end
            else
            begin
                db_cnt_nxt = db_cnt_r + TICK_W'(1);
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            mr_act_r <= 1'b0;
            db_cnt_r <= '0;
        end
        else
        begin
            mr_act_r <= mr_act_nxt;
            db_cnt_r <= db_cnt_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Reset hold and watchdog
    // ---------------------------------------------------------------
    logic rst_r;
    logic rst_nxt;
    logic [TICK_W-1:0] hold_cnt_r;
    logic [TICK_W-1:0] hold_cnt_nxt;
    logic [TICK_W-1:0] wd_cnt_r;
    logic [TICK_W-1:0] wd_cnt_nxt;
    logic wd_exp_r;
    logic wd_exp_nxt;
    logic stb_prev_r;
    logic stb_prev_nxt;
    logic stb_fall;
    logic any_src;
    logic [TICK_W-1:0] wd_limit;

    // Select is read live; a change mid-count applies from the next tick
    always_comb
    begin
        case (I_TIMEOUT_SELECT) // see [RULE8]
            PSW_TD_GND: wd_limit = TICK_W'(WD_GND_T);
            PSW_TD_FLOAT: wd_limit = TICK_W'(WD_FLOAT_T);
            PSW_TD_VCC: wd_limit = TICK_W'(WD_VCC_T);
            // Unused code treated as the longest setting
            default: wd_limit = TICK_W'(WD_VCC_T);
        endcase
    end

    // Edge is taken after the synchroniser; pulses under one clock are seen only if they span a rising edge
    assign stb_fall = stb_prev_r && !stb_n_s;
    // Power fail bypasses the tick so it acts within a few cycles
    assign any_src = pfail_s || mr_act_r || wd_exp_r; // see [RULE1] [RULE3] [RULE15]

    always_comb
    begin
        rst_nxt = rst_r;
        hold_cnt_nxt = hold_cnt_r;
        wd_cnt_nxt = wd_cnt_r;
        wd_exp_nxt = 1'b0;
        stb_prev_nxt = stb_n_s;
        if (any_src)
        begin
            rst_nxt = 1'b1; // see [RULE1] [RULE5] [RULE11]
            hold_cnt_nxt = '0; // see [RULE15] [RULE2] [RULE6]
            wd_cnt_nxt = '0;
        end
        else if (rst_r)
        begin
            wd_cnt_nxt = '0;
            if (tick)
            begin
                if (hold_cnt_r >= TICK_W'(HOLD_T - 1))
                begin
                    rst_nxt = 1'b0; // see [RULE2] [RULE6] [RULE11]
                end
                else
                begin
                    hold_cnt_nxt = hold_cnt_r + TICK_W'(1);
                end
            end
        end
        else
        begin
            // No disable path: counting runs whenever reset is released
            hold_cnt_nxt = '0;
            if (stb_fall)
            begin
                wd_cnt_nxt = '0; // see [RULE10]
            end
            else if (tick)
            begin
                if (wd_cnt_r >= wd_limit - TICK_W'(1))
                begin
                    wd_exp_nxt = 1'b1; // see [RULE11] [RULE13]
                    wd_cnt_nxt = '0;
                end
                else
                begin
                    wd_cnt_nxt = wd_cnt_r + TICK_W'(1); // see [RULE9]
                end
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            // Power-up begins with a full hold period
            rst_r <= 1'b1;
            hold_cnt_r <= '0;
            wd_cnt_r <= '0;
            wd_exp_r <= 1'b0;
            stb_prev_r <= 1'b1;
        end
        else
        begin
            rst_r <= rst_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            wd_exp_r <= wd_exp_nxt;
            stb_prev_r <= stb_prev_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    logic o_rst_r;
    logic o_rst_nxt;
    logic o_oe_r;
    logic o_oe_nxt;
    logic o_exp_r;
    logic o_exp_nxt;

    // Both resets come from one next value, so no cycle shows them apart
    always_comb
    begin
        o_rst_nxt = rst_nxt; // see [RULE4]
        o_oe_nxt = rst_nxt; // see [RULE4]
        o_exp_nxt = wd_exp_nxt;
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            o_rst_r <= 1'b1;
            o_oe_r <= 1'b1;
            o_exp_r <= 1'b0;
        end
        else
        begin
            o_rst_r <= o_rst_nxt;
            o_oe_r <= o_oe_nxt;
            o_exp_r <= o_exp_nxt;
        end
    end

    assign O_RESET = o_rst_r;
    // Open drain: only ever drives low, released otherwise
    assign O_RESET_N_OUT = 1'b0;
    assign O_RESET_N_OE = o_oe_r;
    assign O_WATCHDOG_EXPIRED = o_exp_r;

endmodule : psw_top

//--- sim/processor_supervisor_watchdog_reset_test.sv
// Testbench: supervisor reset sources, hold times and watchdog
module processor_supervisor_watchdog_reset_test
import psw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened counts, one tick per cycle
    localparam int HT = 50;
    localparam int DT = 5;
    localparam int WG = 100;
    localparam int WF = 200;
    localparam int WV = 300;
    logic clk = 1'b0, rst = 1'b1, pf = 1'b0, mr_n = 1'b1, en = 1'b0, bad;
    logic o_rst, o_n, o_oe, o_exp;
    wire logic st_n;
    psw_td_t sel = PSW_TD_GND;
    logic [15:0] per = 16'h0020;
    logic [31:0] seed = 32'h99eccfa3;
    int failures = 0, comparisons = 0, n;
    always #50 clk = ~clk;
    psw_top #(.HOLD_T(HT), .DEBOUNCE_T(DT), .WD_GND_T(WG), .WD_FLOAT_T(WF),
        .WD_VCC_T(WV), .TICK_DIV(1)) psw_top_inst (.I_SYS_CLK(clk), .I_RST(rst),
        .I_POWER_FAIL(pf), .I_MANUAL_RESET_N(mr_n), .I_WATCHDOG_STROBE_N(st_n),
        .I_TIMEOUT_SELECT(sel), .O_RESET(o_rst), .O_RESET_N_OUT(o_n),
        .O_RESET_N_OE(o_oe), .O_WATCHDOG_EXPIRED(o_exp));
    psw_cpu_model psw_cpu_model_inst (.i_clk(clk), .i_en(en), .i_period(per),
        .o_strobe_n(st_n));
    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic int wd_lim(input psw_td_t s);
        return (s == PSW_TD_GND) ? WG : (s == PSW_TD_FLOAT) ? WF : WV;
    endfunction : wd_lim
    task automatic final_report;
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // Bounded wait on reset or expiry flag; cycles taken in cnt
    task automatic wait_out(input logic v, input logic pick, input int max, output int cnt);
        cnt = 0;
        while (((pick ? o_exp : o_rst) !== v) && cnt < max)
        begin
            tick(1);
            cnt++;
        end
        if ((pick ? o_exp : o_rst) !== v)
        begin
            failures++;
            final_report();
        end
    endtask : wait_out
    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial
    begin
        for (int r = 0; r < 2; r++)
        begin
            rst = 1'b1;
            tick(3);
            check("rst_during_reset", o_rst, 1'b1);
            check("oe_during_reset", o_oe, 1'b1);
            rst = 1'b0;
            wait_out(1'b0, 1'b0, HT + 20, n);
            check("powerup_hold", n >= HT && n <= HT + 10, 1'b1);
            check("drain_data", o_n, 1'b0);
            check("oe_released", o_oe, 1'b0);
        end
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            pf = 1'b1;
            wait_out(1'b1, 1'b0, 8, n);
            check("pfail_delay", n <= 5, 1'b1);
            tick(seed[2:0]);
            pf = 1'b0;
            wait_out(1'b0, 1'b0, HT + 20, n);
            check("pfail_hold", n >= HT && n <= HT + 10, 1'b1);
        end
        // Glitch shorter than the debounce must be ignored
        mr_n = 1'b0;
        tick(DT - 3);
        mr_n = 1'b1;
        tick(DT + 10);
        check("mr_glitch", o_rst, 1'b0);
        mr_n = 1'b0;
        wait_out(1'b1, 1'b0, 4 * DT, n);
        check("mr_delay", n >= DT && n <= DT + 8, 1'b1);
        tick(20);
        mr_n = 1'b1;
        wait_out(1'b0, 1'b0, HT + DT + 20, n);
        check("mr_hold", n >= HT && n <= HT + DT + 10, 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            sel = psw_td_t'(s);
            pf = 1'b1;
            tick(6);
            pf = 1'b0;
            wait_out(1'b0, 1'b0, HT + 20, n);
            wait_out(1'b1, 1'b1, wd_lim(sel) + 10, n);
            check("wd_timeout", n >= wd_lim(sel) - 1 && n <= wd_lim(sel) + 3, 1'b1);
            tick(1);
            check("wd_reset", o_rst, 1'b1);
            wait_out(1'b0, 1'b0, HT + 20, n);
            check("wd_hold", n >= HT - 2 && n <= HT + 10, 1'b1);
            seed = xs(seed);
            // Period stays under the minimum timeout, 5/12 of the typical one
            per = 16'(wd_lim(sel) / 4 + seed[3:0]);
            en = 1'b1;
            bad = 1'b0;
            repeat (3 * wd_lim(sel))
            begin
                tick(1);
                bad = bad | o_rst | o_exp;
            end
            check("wd_kept_alive", bad, 1'b0);
            en = 1'b0;
        end
        final_report();
    end
endmodule : processor_supervisor_watchdog_reset_test

//--- sim/psw_cpu_model.sv
// Model of the supervised processor strobing the watchdog
module psw_cpu_model
(
    // Clock and control
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [15:0] i_period,
    // Strobe to the supervisor
    output logic o_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_r = 16'h0000;
    initial o_strobe_n = 1'b1;
    // Period is kept under the shortest timeout of the setting in use
    always @(posedge i_clk)
    begin
        cnt_r <= #1 (!i_en || cnt_r >= i_period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
        o_strobe_n <= #1 !(i_en && cnt_r < 16'h0002);
    end
endmodule : psw_cpu_model

//--- sim/psw_props.sv
// Checker: timing relations on the supervisor top ports
module psw_props
import psw_pkg::*;
#(
    parameter int HOLD_T = 50,
    parameter int DEBOUNCE_T = 5,
    parameter int WD_GND_T = 100,
    parameter int WD_FLOAT_T = 200,
    parameter int WD_VCC_T = 300,
    parameter int TICK_DIV = 1
)
(
    // Clock, reset and sources
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_POWER_FAIL,
    input wire logic I_MANUAL_RESET_N,
    input wire logic I_WATCHDOG_STROBE_N,
    input wire psw_pkg::psw_td_t I_TIMEOUT_SELECT,
    // Outputs watched
    input wire logic O_RESET,
    input wire logic O_RESET_N_OUT,
    input wire logic O_RESET_N_OE,
    input wire logic O_WATCHDOG_EXPIRED
);
    // ---------------------------------------------------------
    // Helper counters
    // ---------------------------------------------------------
    int q_cnt_r, q_cnt_nxt, m_cnt_r, m_cnt_nxt, s_cnt_r, s_cnt_nxt, lim;
    logic st_r, st_nxt;
    always_comb
    begin
        // Any source restarts the count, expiry included
        q_cnt_nxt = (I_RST || I_POWER_FAIL || !I_MANUAL_RESET_N || O_WATCHDOG_EXPIRED) ? 0
            : q_cnt_r + 1;
        m_cnt_nxt = (I_RST || I_MANUAL_RESET_N) ? 0 : m_cnt_r + 1;
        // Raw strobe edge: clears earlier than the design's synced one
        s_cnt_nxt = (I_RST || O_RESET || (st_r && !I_WATCHDOG_STROBE_N)) ? 0 : s_cnt_r + 1;
        st_nxt = I_WATCHDOG_STROBE_N;
        case (I_TIMEOUT_SELECT)
            PSW_TD_GND: lim = WD_GND_T * TICK_DIV;
            PSW_TD_FLOAT: lim = WD_FLOAT_T * TICK_DIV;
            default: lim = WD_VCC_T * TICK_DIV;
        endcase
    end
    always_ff @(posedge I_SYS_CLK)
    begin
        q_cnt_r <= q_cnt_nxt;
        m_cnt_r <= m_cnt_nxt;
        s_cnt_r <= s_cnt_nxt;
        st_r <= st_nxt;
    end
    // ---------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence s_expire;
        O_WATCHDOG_EXPIRED;
    endsequence
    sequence s_held;
        O_RESET [*8];
    endsequence
    a_drain_pair: assert property (O_RESET_N_OE == O_RESET)
        else $error("drain enable differs from reset");
    a_drain_zero: assert property (O_RESET_N_OUT == 1'b0)
        else $error("drain data not low");
    a_pfail_fast: assert property ($rose(I_POWER_FAIL) |-> ##[0:5] O_RESET)
        else $error("power fail reset late");
    a_pfail_level: assert property (I_POWER_FAIL [*5] |-> O_RESET)
        else $error("power fail without reset");
    a_hold_min: assert property ($fell(O_RESET) |-> q_cnt_r >= HOLD_T * TICK_DIV)
        else $error("reset released too early");
    a_manual_assert: assert property (m_cnt_r >= DEBOUNCE_T * TICK_DIV + 6 |-> O_RESET)
        else $error("manual reset not asserted");
    a_wdog_late: assert property (s_expire |-> s_cnt_r >= lim - 1 || s_cnt_r < 4)
        else $error("watchdog expired early");
    a_wdog_due: assert property (s_cnt_r >= lim + 6 |-> O_RESET)
        else $error("watchdog did not expire");
    a_expire_hold: assert property (s_expire |=> s_held)
        else $error("expiry reset not held");
    a_expire_pulse: assert property (s_expire |=> !O_WATCHDOG_EXPIRED)
        else $error("expiry flag longer than one cycle");
endmodule : psw_props

bind psw_top psw_props #(
    .HOLD_T(HOLD_T), .DEBOUNCE_T(DEBOUNCE_T), .WD_GND_T(WD_GND_T),
    .WD_FLOAT_T(WD_FLOAT_T), .WD_VCC_T(WD_VCC_T), .TICK_DIV(TICK_DIV)
) psw_props_inst (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_POWER_FAIL(I_POWER_FAIL),
    .I_MANUAL_RESET_N(I_MANUAL_RESET_N), .I_WATCHDOG_STROBE_N(I_WATCHDOG_STROBE_N),
    .I_TIMEOUT_SELECT(I_TIMEOUT_SELECT), .O_RESET(O_RESET), .O_RESET_N_OUT(O_RESET_N_OUT),
    .O_RESET_N_OE(O_RESET_N_OE), .O_WATCHDOG_EXPIRED(O_WATCHDOG_EXPIRED)
);
